// file: hdl/uarx_rx_top.v
// Notes on behaviour
// - Sixteen samples per bit, eight in double speed
// - Falling edge on idle line starts qualification
// - Start vote samples 8-10, or 4-6
// - Majority high start is noise; resume search
// - Resynchronise on every start bit
// - Per-bit sample state counter, 16 or 8
// - Bit value is majority of centre samples
// - Recover through first stop bit only
// - Zero first stop bit on a stored frame sets framing error
// - New start accepted right after stop vote
// - Filter drops data frames when enabled
// - Filter never touches transmitter behaviour
// - Type is stop bit, or ninth bit
// - Type one means address, zero data
// - Accepted address frame stored like normal
// - One character size shared with transmitter
// - Double speed halves samples per bit to eight
`include "uarx_regs.vh"
module uarx_rx_top #(
  parameter BAUD_W = 12
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxPin,
  output reg  [2:0]  charSize,
  output reg         doubleSpeedSelect
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_START = 3'b010;
  localparam [2:0] ST_BITS  = 3'b100;
  localparam [6:0] CTRL_RST = `UARX_CTRL_RST;

  wire rxSync;
  reg  rxPrev_r;
  reg  [2:0] state_r;
  reg  [4:0] sampleIdx_r;
  reg  [3:0] bitIdx_r;
  reg  [2:0] votes_r;
  reg  [9:0] shift_r;
  reg  [BAUD_W-1:0] baudCnt_r;
  reg  [BAUD_W-1:0] baudDiv_r;
  reg        rxEnable_r;
  reg        mpFilterEnable_r;
  reg        parityEnable_r;
  reg  [8:0] dataBuf_r;
  reg        rxComplete_r;
  reg        frameErr_r;
  reg        ninthBit_r;
  reg        busy_r;

  wire       tick;
  wire [4:0] spb;
  wire [4:0] voteFirst;
  wire       inVote;
  wire       voteLast;
  wire       majority;
  wire [3:0] dataBits;
  wire [3:0] frameBits;
  wire       apbAccess;
  wire       readData;
  wire       frameDone;
  wire       typeBit;
  wire       keepFrame;
  wire [8:0] dataMasked;
  wire       stopVote;
  wire [9:0] fullFrame;

  uarx_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .din  (rxPin),
    .dout (rxSync)
  );

  // ----------------------------------------
  // Oversampling tick
  // ----------------------------------------
  assign tick = (baudCnt_r == {BAUD_W{1'b0}});

  always @(posedge clk) begin
    if (srst) begin
      baudCnt_r <= {BAUD_W{1'b0}};
    end else if (ce) begin
      if (tick) begin
        baudCnt_r <= baudDiv_r;
      end else begin
        baudCnt_r <= baudCnt_r - {{(BAUD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // Sampling geometry
  // ----------------------------------------
  assign spb       = doubleSpeedSelect ? `UARX_SPB_DBL : `UARX_SPB_NORM;
  assign voteFirst = doubleSpeedSelect ? `UARX_VOTE_DBL : `UARX_VOTE_NORM;
  assign inVote    = (sampleIdx_r >= voteFirst) && (sampleIdx_r <= voteFirst + 5'h02);
  assign voteLast  = (sampleIdx_r == voteFirst + 5'h02);
  assign majority  = (votes_r[0] & votes_r[1]) | (votes_r[0] & votes_r[2])
                   | (votes_r[1] & votes_r[2]);
  assign dataBits  = charSize[2] ? 4'h9 : {2'b00, charSize[1:0]} + 4'h5;
  // Start excluded: data, optional parity, first stop
  assign frameBits = dataBits + {3'h0, parityEnable_r} + 4'h1;
  assign frameDone = (state_r == ST_BITS) && tick && voteLast
                   && (bitIdx_r == frameBits - 4'h1);

  // ----------------------------------------
  // Frame assembly and filtering
  // ----------------------------------------
  // Stop vote folds in the live third sample, not yet shifted in
  assign stopVote   = (votes_r[1] & votes_r[0]) | (votes_r[1] & rxSync)
                    | (votes_r[0] & rxSync);
  assign fullFrame  = {stopVote, shift_r[9:1]} >> (4'ha - frameBits);
  assign dataMasked = fullFrame[8:0] & ~({9{1'b1}} << dataBits);
  assign typeBit    = (dataBits == 4'h9) ? fullFrame[8] : stopVote;
  assign keepFrame  = ~mpFilterEnable_r | typeBit;

  // ----------------------------------------
  // Receive state machine
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      sampleIdx_r <= 5'h00;
      bitIdx_r    <= 4'h0;
      votes_r     <= 3'h0;
      shift_r     <= 10'h000;
      rxPrev_r    <= 1'b1;
      busy_r      <= 1'b0;
    end else if (ce) begin
      if (!rxEnable_r) begin
        state_r <= ST_IDLE;
        busy_r  <= 1'b0;
        rxPrev_r <= 1'b1;
      end else if (tick) begin
        rxPrev_r <= rxSync;
        case (state_r)
          ST_IDLE: begin
            if (rxPrev_r && !rxSync) begin
              state_r     <= ST_START;
              sampleIdx_r <= 5'h02;
              busy_r      <= 1'b1;
            end
          end
          ST_START: begin
            sampleIdx_r <= sampleIdx_r + 5'h01;
            if (inVote) begin
              votes_r <= {votes_r[1:0], rxSync};
            end
            if (sampleIdx_r == voteFirst + 5'h03) begin
              if (majority) begin
                state_r  <= ST_IDLE;
                busy_r   <= 1'b0;
              end
            end
            if (sampleIdx_r == spb) begin
              state_r     <= ST_BITS;
              sampleIdx_r <= 5'h01;
              bitIdx_r    <= 4'h0;
            end
          end
          ST_BITS: begin
            sampleIdx_r <= (sampleIdx_r == spb) ? 5'h01 : sampleIdx_r + 5'h01;
            if (inVote) begin
              votes_r <= {votes_r[1:0], rxSync};
            end
            if (sampleIdx_r == voteFirst + 5'h03) begin
              shift_r  <= {majority, shift_r[9:1]};
            end
            if (sampleIdx_r == spb) begin
              bitIdx_r <= bitIdx_r + 4'h1;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
        if (frameDone) begin
          state_r  <= ST_IDLE;
          busy_r   <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apbAccess = psel && penable && !pready;
  assign readData  = apbAccess && !pwrite && (paddr == `UARX_DATA_OFF);

  always @(posedge clk) begin
    if (srst) begin
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      rxEnable_r        <= CTRL_RST[`UARX_CTRL_EN_BIT];
      doubleSpeedSelect <= 1'b0;
      mpFilterEnable_r  <= 1'b0;
      charSize          <= CTRL_RST[`UARX_CTRL_SZ_MSB:`UARX_CTRL_SZ_LSB];
      parityEnable_r    <= 1'b0;
      baudDiv_r         <= `UARX_BAUD_RST;
      dataBuf_r         <= 9'h000;
      rxComplete_r      <= 1'b0;
      frameErr_r        <= 1'b0;
      ninthBit_r        <= 1'b0;
    end else if (ce) begin
      pready  <= apbAccess;
      pslverr <= 1'b0;
      if (apbAccess) begin
        prdata <= 32'h0000_0000;
        if (paddr == `UARX_CTRL_OFF) begin
          if (pwrite) begin
            rxEnable_r        <= pwdata[`UARX_CTRL_EN_BIT];
            doubleSpeedSelect <= pwdata[`UARX_CTRL_DS_BIT];
            mpFilterEnable_r  <= pwdata[`UARX_CTRL_MP_BIT];
            charSize          <= pwdata[`UARX_CTRL_SZ_MSB:`UARX_CTRL_SZ_LSB];
            parityEnable_r    <= pwdata[`UARX_CTRL_PAR_BIT];
          end
          prdata <= {25'h0, parityEnable_r, charSize, mpFilterEnable_r,
                     doubleSpeedSelect, rxEnable_r};
        end else if (paddr == `UARX_STAT_OFF) begin
          prdata <= {28'h0, busy_r, ninthBit_r, frameErr_r, rxComplete_r};
        end else if (paddr == `UARX_DATA_OFF) begin
          prdata <= {23'h0, dataBuf_r};
        end else if (paddr == `UARX_BAUD_OFF) begin
          if (pwrite) begin
            baudDiv_r <= pwdata[BAUD_W-1:0];
          end
          prdata <= {{(32-BAUD_W){1'b0}}, baudDiv_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
      // Read of data clears the flag; a frame landing the same cycle wins
      if (readData) begin
        rxComplete_r <= 1'b0;
      end
      if (!rxEnable_r) begin
        rxComplete_r <= 1'b0;
      end
      if (frameDone && keepFrame && rxEnable_r) begin
        dataBuf_r    <= dataMasked;
        ninthBit_r   <= (dataBits == 4'h9) & fullFrame[8];
        frameErr_r   <= ~stopVote;
        rxComplete_r <= 1'b1;
      end
    end
  end
endmodule // uarx_rx_top

// file: include/uarx_regs.vh
`ifndef UARX_REGS_VH
`define UARX_REGS_VH
// ----------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------
`define UARX_CTRL_OFF      12'h000
`define UARX_STAT_OFF      12'h004
`define UARX_DATA_OFF      12'h008
`define UARX_BAUD_OFF      12'h00c
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define UARX_CTRL_EN_BIT   0
`define UARX_CTRL_DS_BIT   1
`define UARX_CTRL_MP_BIT   2
`define UARX_CTRL_SZ_LSB   3
`define UARX_CTRL_SZ_MSB   5
`define UARX_CTRL_PAR_BIT  6
`define UARX_CTRL_RST      7'h18
// ----------------------------------------
// Status field positions
// ----------------------------------------
`define UARX_STAT_RXC_BIT  0
`define UARX_STAT_FE_BIT   1
`define UARX_STAT_NINE_BIT 2
`define UARX_STAT_BUSY_BIT 3
`define UARX_BAUD_RST      12'h000
// ----------------------------------------
// Sampling constants
// ----------------------------------------
`define UARX_SPB_NORM      5'h10
`define UARX_SPB_DBL       5'h08
`define UARX_VOTE_NORM     5'h08
`define UARX_VOTE_DBL      5'h04
`define UARX_SZ_NINE       3'h7
`endif

// file: hdl/uarx_sync.v
module uarx_sync (
  input  wire clk,
  input  wire srst,
  input  wire ce,
  input  wire din,
  output wire dout
);
  reg stage1_r;
  reg stage2_r;

  always @(posedge clk) begin
    if (srst) begin
      stage1_r <= 1'b1;
      stage2_r <= 1'b1;
    end else if (ce) begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;
endmodule // uarx_sync

// file: bench/uarx_rx_chk.sv
`include "uarx_regs.vh"
module uarx_rx_chk #(
  parameter BAUD_W = 12
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxPin,
  input wire logic [2:0]  charSize,
  input wire logic        doubleSpeedSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        take;
  logic        ctrlWr;
  logic [31:0] wdPrev_r;
  assign take   = psel && penable && !pready && ce;
  assign ctrlWr = take && pwrite && paddr == `UARX_CTRL_OFF;
  always_ff @(posedge clk) wdPrev_r <= pwdata;
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  ready_after_take_a: assert property (take |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone slverr");
  unmapped_err_a: assert property (take && paddr >= 12'h010 |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (take && paddr < 12'h010 |=> !pslverr) else $error("bad slverr");
  size_write_a: assert property (ctrlWr |=> charSize == wdPrev_r[5:3])
    else $error("size not written");
  dbl_write_a: assert property (ctrlWr |=> doubleSpeedSelect == wdPrev_r[1])
    else $error("double speed not written");
  size_hold_a: assert property (!ctrlWr |=> $stable(charSize) && $stable(doubleSpeedSelect))
    else $error("size changed");
  reset_vals_a: assert property ($fell(srst) |-> charSize == 3'h3 && !doubleSpeedSelect && !pready)
    else $error("reset values");
  cover property (ctrlWr && pwdata[2]);
  cover property (ctrlWr && pwdata[1]);
  cover property (pready && pslverr);
endmodule // uarx_rx_chk

// file: bench/uarx_tx_model.sv
module uarx_tx_model (
  input  wire logic clk,
  output logic      rxPin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxPin = 1'b1;
  task automatic bitOut(input logic v, input int spb);
    rxPin <= v;
    repeat (spb) @(posedge clk);
  endtask
  // Start, data lsb first, type or stop bit, extra idle stops
  task automatic send(input logic [8:0] d, input int nd, input logic stp, input int st2,
                      input int spb);
    int i;
    bitOut(1'b0, spb);
    for (i = 0; i < nd; i++) bitOut(d[i], spb);
    bitOut(stp, spb);
    for (i = 0; i < st2; i++) bitOut(1'b1, spb);
    rxPin <= 1'b1;
  endtask
  task automatic glitch(input int n);
    bitOut(1'b0, n);
    bitOut(1'b1, 40);
  endtask
endmodule // uarx_tx_model

// file: bench/uarx_rx_tb_top.sv
`include "uarx_regs.vh"
module uarx_rx_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst, ce, psel, penable, pwrite, pready, pslverr, rxPin, doubleSpeedSelect, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  charSize;
  int          err_count = 0;
  int          n_tests = 0;
  always #4 clk = ~clk;
  uarx_rx_top #(.BAUD_W(12)) i_uarx_rx_top (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxPin(rxPin), .charSize(charSize),
    .doubleSpeedSelect(doubleSpeedSelect));
  uarx_tx_model i_uarx_tx_model (.clk(clk), .rxPin(rxPin));
  task automatic finish_test();
    $display("errors=%0d compares=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
    chk({31'h0, er}, {31'h0, a >= 12'h010});
  endtask
  initial begin
    int s;
    {srst, ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b1, 47'h0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdc(`UARX_CTRL_OFF, 32'h18, '1);
    rdc(`UARX_BAUD_OFF, 32'h0, '1);
    rdc(12'h010, 32'h0, '1);
    for (s = 0; s < 4; s++) begin
      apb(1'b1, `UARX_CTRL_OFF, 32'(s * 8 + 1));
      chk({29'h0, charSize}, 32'(s));
      i_uarx_tx_model.send(9'h0d6, 5 + s, 1'b1, 0, 16);
      rdc(`UARX_STAT_OFF, 32'h1, 32'h3);
      rdc(`UARX_DATA_OFF, 32'hd6 & ((32'h1 << (5 + s)) - 1), '1);
    end
    i_uarx_tx_model.glitch(8);
    rdc(`UARX_STAT_OFF, 32'h0, 32'h1);
    i_uarx_tx_model.send(9'h03c, 8, 1'b1, 0, 16);
    i_uarx_tx_model.send(9'h0c3, 8, 1'b1, 0, 16);
    rdc(`UARX_DATA_OFF, 32'hc3, '1);
    i_uarx_tx_model.send(9'h055, 8, 1'b0, 1, 16);
    rdc(`UARX_STAT_OFF, 32'h3, 32'h3);
    rdc(`UARX_DATA_OFF, 32'h55, '1);
    apb(1'b1, `UARX_CTRL_OFF, 32'h1b);
    chk({31'h0, doubleSpeedSelect}, 32'h1);
    i_uarx_tx_model.glitch(4);
    rdc(`UARX_STAT_OFF, 32'h0, 32'h1);
    i_uarx_tx_model.send(9'h05a, 8, 1'b1, 0, 8);
    rdc(`UARX_DATA_OFF, 32'h5a, '1);
    apb(1'b1, `UARX_CTRL_OFF, 32'h1d);
    i_uarx_tx_model.send(9'h011, 8, 1'b0, 1, 16);
    rdc(`UARX_STAT_OFF, 32'h0, 32'h1);
    i_uarx_tx_model.send(9'h022, 8, 1'b1, 1, 16);
    rdc(`UARX_STAT_OFF, 32'h1, 32'h3);
    rdc(`UARX_DATA_OFF, 32'h22, '1);
    apb(1'b1, `UARX_CTRL_OFF, 32'h3d);
    i_uarx_tx_model.send(9'h033, 9, 1'b1, 0, 16);
    rdc(`UARX_STAT_OFF, 32'h0, 32'h1);
    i_uarx_tx_model.send(9'h144, 9, 1'b1, 0, 16);
    rdc(`UARX_STAT_OFF, 32'h5, 32'h7);
    rdc(`UARX_DATA_OFF, 32'h144, '1);
    apb(1'b1, `UARX_CTRL_OFF, 32'h39);
    i_uarx_tx_model.send(9'h033, 9, 1'b1, 0, 16);
    rdc(`UARX_DATA_OFF, 32'h033, '1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(`UARX_CTRL_OFF, 32'h18, '1);
    rdc(`UARX_STAT_OFF, 32'h0, '1);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule // uarx_rx_tb_top
bind uarx_rx_top uarx_rx_chk #(.BAUD_W(BAUD_W)) i_uarx_rx_chk (.clk(clk), .srst(srst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxPin), .charSize(charSize),
  .doubleSpeedSelect(doubleSpeedSelect));
